// >>> common/usb_global_regs_map.vh
`ifndef USB_GLOBAL_REGS_MAP_VH
`define USB_GLOBAL_REGS_MAP_VH
// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_GLOBAL_CONTROL 8'hbc
`define IDX_EVENT_FLAGS 8'hbd
`define IDX_EVENT_ENABLES 8'hbe
`define IDX_FUNCTION_ADDRESS 8'hc6
`define IDX_ENDPOINT_SELECT 8'hc7
// ------------------------------------------------------------
// field positions and masks
// ------------------------------------------------------------
`define BIT_WAKE 5
`define BIT_END_OF_RESET 4
`define BIT_FRAME_START 3
`define BIT_SUSPEND 0
`define EVENT_MASK 8'h39
`define EP_SELECT_MASK 8'h0f
`define CTRL_MASK 8'h43
`define BIT_FUNCTION_ENABLE 7
`define BIT_SUSPEND_CLOCK 6
`define BIT_CONFIGURED 1
`define BIT_ADDRESS_ENABLE 0
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_EVENT_FLAGS 8'h00
`define RST_EVENT_ENABLES 8'h10
`define RST_FUNCTION_ADDRESS 8'h00
`define RST_ENDPOINT_SELECT 8'h00
`define RST_CONTROL 8'h00
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_HZ 20000000
`define SUSPEND_IDLE_US 3000
`define SUSPEND_IDLE_CYCLES ((`SUSPEND_IDLE_US * (`CLK_HZ / 1000000)))
`define RESET_SE0_BIT_TIMES 32
`define FS_BIT_HZ 12000000
`define RESET_SE0_CYCLES (((`RESET_SE0_BIT_TIMES * `CLK_HZ) + `FS_BIT_HZ - 1) / `FS_BIT_HZ)
`endif

// >>> hdl/event_flag.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// sticky event flag, hardware set beats software clear
// ------------------------------------------------------------
module event_flag (
  input  wire clk,
  input  wire rst_n,
  input  wire set,
  input  wire clear,
  output reg  flag
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule // event_flag

// >>> hdl/usb_global_regs.v
`timescale 1ns/1ps
`include "usb_global_regs_map.vh"
module usb_global_regs #(
  parameter SUSPEND_CYCLES = `SUSPEND_IDLE_CYCLES,
  parameter RESET_CYCLES   = `RESET_SE0_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        line_se0,
  input  wire        line_j,
  input  wire        sof_pid_seen,
  input  wire        upstream_resume,
  output reg         usb_irq,
  output reg         function_enable,
  output reg  [6:0]  answer_address,
  output reg  [3:0]  endpoint_select_field,
  output reg         usb_clock_stop,
  output reg         pads_disabled,
  output reg         configured_control
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {upstream_resume, sof_pid_seen, line_j, line_se0};
      sync_b <= sync_a;
    end
  end
  wire se0_s = sync_b[0];
  wire j_s   = sync_b[1];
  wire sof_s = sync_b[2];
  wire up_s  = sync_b[3];
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [7:0] usb_global_event_enables;
  reg  [7:0] usb_function_address;
  reg  [7:0] usb_endpoint_select;
  reg  [7:0] usb_global_control;
  wire       wake_flag;
  wire       end_of_reset_flag;
  wire       frame_start_flag;
  wire       suspend_flag;
  wire [7:0] usb_global_event_flags = {2'b00, wake_flag, end_of_reset_flag,
                                       frame_start_flag, 2'b00, suspend_flag};
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire [7:0] idx = paddr[9:2];
  wire       access = psel && penable;
  wire       wr = access && pwrite && pstrb[0];
  wire       hit = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0) &&
                   ((idx == `IDX_GLOBAL_CONTROL) || (idx == `IDX_EVENT_FLAGS) ||
                    (idx == `IDX_EVENT_ENABLES) || (idx == `IDX_FUNCTION_ADDRESS) ||
                    (idx == `IDX_ENDPOINT_SELECT));
  wire       wr_flags = wr && hit && (idx == `IDX_EVENT_FLAGS);
  reg  [7:0] rd_val;
  always @* begin
    case (idx)
      `IDX_GLOBAL_CONTROL:   rd_val = usb_global_control;
      `IDX_EVENT_FLAGS:      rd_val = usb_global_event_flags;
      `IDX_EVENT_ENABLES:    rd_val = usb_global_event_enables;
      `IDX_FUNCTION_ADDRESS: rd_val = usb_function_address;
      `IDX_ENDPOINT_SELECT:  rd_val = usb_endpoint_select;
      default:               rd_val = 8'h00;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !((paddr[1:0] == 2'b00) &&
                 (paddr[31:10] == 22'h0) && (paddr[9:2] == `IDX_GLOBAL_CONTROL ||
                 paddr[9:2] == `IDX_EVENT_FLAGS || paddr[9:2] == `IDX_EVENT_ENABLES ||
                 paddr[9:2] == `IDX_FUNCTION_ADDRESS ||
                 paddr[9:2] == `IDX_ENDPOINT_SELECT));
      prdata  <= (psel && !penable && !pwrite && hit) ? {24'h0, rd_val} : 32'h0;
    end
  end
  wire xfer_wr = wr && pready && hit;
  // ------------------------------------------------------------
  // bus reset and suspend detection
  // ------------------------------------------------------------
  reg [7:0]  se0_cnt;
  reg        bus_reset;
  reg [19:0] idle_cnt;
  reg        suspended;
  wire       reset_end = bus_reset && !se0_s;
  wire       idle_done = (idle_cnt == SUSPEND_CYCLES[19:0] - 20'd1) && j_s;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      se0_cnt   <= 8'h00;
      bus_reset <= 1'b0;
      idle_cnt  <= 20'h0;
      suspended <= 1'b0;
    end else begin
      if (!se0_s) begin
        se0_cnt   <= 8'h00;
        bus_reset <= 1'b0;
      end else if (se0_cnt == RESET_CYCLES[7:0] - 8'd1) begin
        bus_reset <= 1'b1;
      end else begin
        se0_cnt <= se0_cnt + 8'd1;
      end
      if (!j_s) begin
        idle_cnt <= 20'h0;
      end else if (!idle_done) begin
        idle_cnt <= idle_cnt + 20'd1;
      end
      if (idle_done) begin
        suspended <= 1'b1;
      end else if (!j_s && !up_s) begin
        suspended <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // event flags
  // ------------------------------------------------------------
  wire wake_set    = suspended && !j_s && !up_s;
  wire suspend_set = idle_done && !suspended;
  event_flag u_wake (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (wake_set),
    .clear (xfer_wr && wr_flags && !pwdata[`BIT_WAKE]),
    .flag  (wake_flag)
  );
  event_flag u_eor (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (reset_end),
    .clear (xfer_wr && wr_flags && !pwdata[`BIT_END_OF_RESET]),
    .flag  (end_of_reset_flag)
  );
  event_flag u_sof (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (sof_s),
    .clear (xfer_wr && wr_flags && !pwdata[`BIT_FRAME_START]),
    .flag  (frame_start_flag)
  );
  event_flag u_susp (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (suspend_set),
    .clear (xfer_wr && wr_flags && !pwdata[`BIT_SUSPEND]),
    .flag  (suspend_flag)
  );
  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_global_event_enables <= `RST_EVENT_ENABLES;
      usb_function_address     <= `RST_FUNCTION_ADDRESS;
      usb_endpoint_select      <= `RST_ENDPOINT_SELECT;
      usb_global_control       <= `RST_CONTROL;
    end else begin
      if (xfer_wr && idx == `IDX_EVENT_ENABLES) begin
        usb_global_event_enables <= pwdata[7:0] & `EVENT_MASK;
      end
      if (xfer_wr && idx == `IDX_ENDPOINT_SELECT) begin
        usb_endpoint_select <= pwdata[7:0] & `EP_SELECT_MASK;
      end
      if (xfer_wr && idx == `IDX_FUNCTION_ADDRESS) begin
        usb_function_address <= pwdata[7:0];
      end else if (bus_reset) begin
        usb_function_address <= {usb_function_address[7], 7'h00};
      end
      if (bus_reset) begin
        usb_global_control[`BIT_CONFIGURED]     <= 1'b0;
        usb_global_control[`BIT_ADDRESS_ENABLE] <= 1'b0;
      end else if (xfer_wr && idx == `IDX_GLOBAL_CONTROL) begin
        usb_global_control <= pwdata[7:0] & `CTRL_MASK;
      end
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_irq               <= 1'b0;
      function_enable       <= 1'b0;
      answer_address        <= 7'h00;
      endpoint_select_field <= 4'h0;
      usb_clock_stop        <= 1'b0;
      pads_disabled         <= 1'b0;
      configured_control    <= 1'b0;
    end else begin
      usb_irq <= |(usb_global_event_flags & usb_global_event_enables);
      function_enable <= usb_function_address[`BIT_FUNCTION_ENABLE];
      answer_address <= usb_global_control[`BIT_ADDRESS_ENABLE] ?
                        usb_function_address[6:0] : 7'h00;
      endpoint_select_field <= usb_endpoint_select[3:0];
      usb_clock_stop <= usb_global_control[`BIT_SUSPEND_CLOCK];
      pads_disabled <= suspend_flag;
      configured_control <= usb_global_control[`BIT_CONFIGURED];
    end
  end
endmodule // usb_global_regs

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int SUSP = 40;
  localparam int RSTC = 4;
  logic        clk, rst_n, psel, penable, pwrite, upstream_resume, er;
  logic [31:0] paddr, pwdata, rd;
  wire  [31:0] prdata;
  wire  [6:0]  answer_address;
  wire  [3:0]  endpoint_select_field;
  wire         pready, pslverr, line_se0, line_j, sof_pid_seen, usb_irq;
  wire         function_enable, usb_clock_stop, pads_disabled, configured_control;
  int          mismatches, cmp_count;
  usb_host_model host (.clk(clk), .line_se0(line_se0), .line_j(line_j),
    .sof_pid_seen(sof_pid_seen));
  usb_global_regs #(.SUSPEND_CYCLES(SUSP), .RESET_CYCLES(RSTC)) dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_se0(line_se0),
    .line_j(line_j), .sof_pid_seen(sof_pid_seen), .upstream_resume(upstream_resume),
    .usb_irq(usb_irq), .function_enable(function_enable), .answer_address(answer_address),
    .endpoint_select_field(endpoint_select_field), .usb_clock_stop(usb_clock_stop),
    .pads_disabled(pads_disabled), .configured_control(configured_control));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer; on a read, d is the expected data
  task automatic bus(input logic wr, input logic [31:0] a, d);
    int n;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wr ? d : 32'h0};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(negedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(negedge clk);
      n++;
    end
    if (n >= 16) begin
      mismatches++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    {rd, er} = {prdata, pslverr};
    @(posedge clk);
    {psel, penable} <= 2'b00;
    if (!wr)
      chk("read data", d, rd);
  endtask
  task automatic t_reset;
    bus(0, 32'h2f4, 32'h00);
    bus(0, 32'h2f8, 32'h10);
    bus(0, 32'h318, 32'h00);
    bus(0, 32'h100, 32'h00);
    chk("unmapped error", 1, er);
    $display("t_reset done");
  endtask
  task automatic t_bus_reset;
    bus(1, 32'h318, 32'h85);
    bus(1, 32'h2f0, 32'h03);
    repeat (2) @(posedge clk);
    chk("answer address", 5, answer_address);
    chk("function enable", 1, function_enable);
    host.bus_reset(RSTC + 8);
    repeat (6) @(posedge clk);
    chk("answer address", 0, answer_address);
    chk("configured", 0, configured_control);
    bus(0, 32'h318, 32'h80);
    bus(0, 32'h2f4, 32'h10);
    chk("irq", 1, usb_irq);
    bus(1, 32'h2f4, 32'h00);
    repeat (2) @(posedge clk);
    chk("irq", 0, usb_irq);
    $display("t_bus_reset done");
  endtask
  task automatic t_frame;
    bus(1, 32'h2f8, 32'h00);
    host.send_sof();
    repeat (4) @(posedge clk);
    bus(0, 32'h2f4, 32'h08);
    chk("irq masked", 0, usb_irq);
    bus(1, 32'h2f8, 32'h08);
    repeat (2) @(posedge clk);
    chk("irq", 1, usb_irq);
    bus(1, 32'h2f4, 32'h39);
    bus(0, 32'h2f4, 32'h08);
    bus(1, 32'h2f4, 32'h00);
    $display("t_frame done");
  endtask
  task automatic t_suspend;
    bus(1, 32'h2f8, 32'h21);
    bus(1, 32'h2f0, 32'h40);
    repeat (2) @(posedge clk);
    chk("clock stop", 1, usb_clock_stop);
    for (int r = 0; r < 2; r++) begin
      upstream_resume <= r[0];
      host.hold_j(1'b1);
      repeat (SUSP + 8) @(posedge clk);
      chk("pads off", 1, pads_disabled);
      chk("irq", 1, usb_irq);
      host.hold_j(1'b0);
      repeat (4) @(posedge clk);
      bus(0, 32'h2f4, r ? 32'h01 : 32'h21);
      bus(1, 32'h2f0, 32'h00);
      bus(1, 32'h2f4, 32'h00);
      upstream_resume <= 1'b0;
      repeat (2) @(posedge clk);
      chk("pads on", 0, pads_disabled);
    end
    $display("t_suspend done");
  endtask
  task automatic t_endpoint;
    bus(1, 32'h31c, 32'h06);
    bus(0, 32'h31c, 32'h06);
    chk("endpoint field", 6, endpoint_select_field);
    $display("t_endpoint done");
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, upstream_resume} = 5'h0;
    {paddr, pwdata} = 64'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bus_reset();
    t_frame();
    t_suspend();
    t_endpoint();
    summarize();
  end
endmodule // tb_top

// >>> verif/usb_global_regs_monitor.sv
`timescale 1ns/1ps
module usb_global_regs_monitor #(
  parameter SUSPEND_CYCLES = 40,
  parameter RESET_CYCLES   = 4
) (
  input wire        clk, rst_n, psel, penable, pwrite, pready,
  input wire        line_se0, line_j, function_enable, pads_disabled,
  input wire [31:0] paddr, pwdata, prdata,
  input wire [6:0]  answer_address,
  input wire [3:0]  endpoint_select_field
);
  logic [15:0] se0_cnt, j_cnt;
  wire         acc = psel && penable && pready;
  wire         flag_wr = acc && pwrite && paddr == 32'h2f4;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      se0_cnt <= 16'h0;
      j_cnt   <= 16'h0;
    end else begin
      se0_cnt <= line_se0 ? se0_cnt + 16'h1 : 16'h0;
      j_cnt   <= line_j ? j_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_access_ready: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_flags_reserved: assert property (acc && !pwrite && paddr == 32'h2f4 |->
    (prdata[7:0] & 8'hc6) == 8'h0) else $error("reserved flag bits set");
  a_flag_sticky: assert property ($fell(pads_disabled) |->
    $past(flag_wr) || $past(flag_wr, 2)) else $error("flag cleared by itself");
  a_fen_write: assert property (acc && pwrite && paddr == 32'h318 |->
    ##2 function_enable == $past(pwdata[7], 2)) else $error("function enable wrong");
  a_epsel_write: assert property (acc && pwrite && paddr == 32'h31c |->
    ##2 endpoint_select_field == $past(pwdata[3:0], 2)) else $error("endpoint field wrong");
  a_bus_reset: assert property (se0_cnt > RESET_CYCLES + 4 |->
    answer_address == 7'h0) else $error("address kept over bus reset");
  a_suspend_idle: assert property (j_cnt > SUSPEND_CYCLES + 6 |->
    pads_disabled) else $error("no suspend after idle");
endmodule // usb_global_regs_monitor
bind usb_global_regs usb_global_regs_monitor #(.SUSPEND_CYCLES(SUSPEND_CYCLES),
  .RESET_CYCLES(RESET_CYCLES)) mon (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .line_se0(line_se0), .line_j(line_j),
  .function_enable(function_enable), .pads_disabled(pads_disabled), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .answer_address(answer_address),
  .endpoint_select_field(endpoint_select_field));

// >>> verif/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  input  wire  clk,
  output logic line_se0,
  output logic line_j,
  output logic sof_pid_seen
);
  initial begin
    {line_se0, line_j, sof_pid_seen} = 3'h0;
  end
  // se0 for n cycles, then back to traffic
  task automatic bus_reset(input int n);
    line_se0 <= 1'b1;
    repeat (n) @(posedge clk);
    line_se0 <= 1'b0;
  endtask
  task automatic send_sof;
    sof_pid_seen <= 1'b1;
    @(posedge clk);
    sof_pid_seen <= 1'b0;
  endtask
  // j is idle, non-j is traffic or resume
  task automatic hold_j(input logic v);
    line_j <= v;
  endtask
endmodule // usb_host_model
